// file: swg_pkg.sv
// Functional notes
// RL1 - CTC modes 4 and 12 clear the counter on match with compare A or capture.
// RL2 - CTC sets compare A flag or capture flag, whichever defines TOP, at TOP.
// RL3 - CTC TOP is not buffered; a missed TOP wraps through 0xFFFF first.
// RL4 - CTC with channel A action 1 toggles wave_out_a on every match.
// RL5 - A wave output reaches its pin only when its direction bit is 1.
// RL6 - CTC overflow flag sets in the tick the counter rolls MAX to 0x0000.
// RL7 - Modes 5, 6, 7, 14, 15 are fast PWM, counting BOTTOM to TOP only.
// RL8 - Fast PWM non-inverting clears on match, sets at BOTTOM; inverting opposite.
// RL9 - Fast PWM action 2 is non-inverted, action 3 inverted.
// RL10 - Fast PWM TOP is fixed, capture or compare A; clears tick after TOP.
// RL11 - Fast PWM sets overflow at TOP, with compare A or capture flag alike.
// RL12 - PWM modes set a channel compare flag whenever count equals its value.
// RL13 - Fixed TOP masks compare bits above the resolution on every write.
// RL14 - Capture TOP is unbuffered; a value below the count wraps through 0xFFFF.
// RL15 - Fast PWM compare A writes go to a buffer, loaded at TOP.
// RL16 - Software keeps new TOP at or above every compare value.
// RL17 - Fast PWM compare 0 gives one-tick spike; compare TOP gives constant level.
// RL18 - Fast PWM toggle on channel A works only in mode 15, 50 percent duty.
// RL19 - Fast PWM resolution is 8, 9, 10 bits fixed or 2 to 16 by register.
// RL20 - Modes 1, 2, 3, 10, 11 are phase correct, counting up then down.
// RL21 - Phase correct non-inverting clears on up match, sets on down match.
// RL22 - Phase correct resolution fixed 8, 9, 10 bits or 2 to 16 by register.
// RL23 - Phase correct TOP by mode; counter holds TOP one tick, then reverses.
// RL24 - Phase correct sets overflow flag every time the counter reaches BOTTOM.
// RL25 - Timer tick is the clock divided by 1, 8, 64, 256 or 1024.
// RL26 - Counter and compare registers are 16 bits; channels share counter, mode.
package swg_pkg;

  typedef enum logic [1:0] {CL_NORMAL, CL_CTC, CL_FAST, CL_PHASE} swg_class_t;

  localparam logic [3:0] MODE_NORMAL   = 4'h0;
  localparam logic [3:0] MODE_PC8      = 4'h1;
  localparam logic [3:0] MODE_PC9      = 4'h2;
  localparam logic [3:0] MODE_PC10     = 4'h3;
  localparam logic [3:0] MODE_CTC_CMP  = 4'h4;
  localparam logic [3:0] MODE_FAST8    = 4'h5;
  localparam logic [3:0] MODE_FAST9    = 4'h6;
  localparam logic [3:0] MODE_FAST10   = 4'h7;
  localparam logic [3:0] MODE_PC_CAP   = 4'hA;
  localparam logic [3:0] MODE_PC_CMP   = 4'hB;
  localparam logic [3:0] MODE_CTC_CAP  = 4'hC;
  localparam logic [3:0] MODE_FAST_CAP = 4'hE;
  localparam logic [3:0] MODE_FAST_CMP = 4'hF;

  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;

  localparam logic [15:0] TOP_8    = 16'h00FF;
  localparam logic [15:0] TOP_9    = 16'h01FF;
  localparam logic [15:0] TOP_10   = 16'h03FF;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] BOTTOM   = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  localparam logic [15:0] CMP_RST  = 16'h0000;

  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [2:0] CS_DIV1    = 3'h1;
  localparam logic [2:0] CS_DIV8    = 3'h2;
  localparam logic [2:0] CS_DIV64   = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] LAST_8     = 10'h007;
  localparam logic [9:0] LAST_64    = 10'h03F;
  localparam logic [9:0] LAST_256   = 10'h0FF;
  localparam logic [9:0] LAST_1024  = 10'h3FF;
  localparam logic [9:0] PRE_RST    = 10'h000;

  typedef struct packed {
    logic [3:0] waveform_mode_select;
    logic [2:0] clock_select;
    logic [1:0] channel_a_output_action;
    logic [1:0] channel_b_output_action;
    logic       pin_direction_a;
    logic       pin_direction_b;
  } swg_ctrl_t;

  typedef struct packed {
    logic        wr_compare_a;
    logic        wr_compare_b;
    logic        wr_capture;
    logic [15:0] data;
  } swg_write_t;

  typedef struct packed {
    logic overflow_flag;
    logic compare_a_flag;
    logic compare_b_flag;
    logic capture_flag;
  } swg_flags_t;

  function automatic swg_class_t mode_class(input logic [3:0] m);
    unique case (m)
      MODE_PC8, MODE_PC9, MODE_PC10, MODE_PC_CAP, MODE_PC_CMP: mode_class = CL_PHASE;
      MODE_FAST8, MODE_FAST9, MODE_FAST10,
      MODE_FAST_CAP, MODE_FAST_CMP:                          mode_class = CL_FAST;
      MODE_CTC_CMP, MODE_CTC_CAP:                            mode_class = CL_CTC;
      default:                                               mode_class = CL_NORMAL;
    endcase
  endfunction

  // Fixed TOP for modes 1-3, 5-7; all ones otherwise
  function automatic logic [15:0] fixed_top(input logic [3:0] m);
    unique case (m)
      MODE_PC8, MODE_FAST8:   fixed_top = TOP_8;
      MODE_PC9, MODE_FAST9:   fixed_top = TOP_9;
      MODE_PC10, MODE_FAST10: fixed_top = TOP_10;
      default:                fixed_top = CNT_MAX;
    endcase
  endfunction

endpackage

// file: swg_prescaler.sv
`timescale 1ns/1ns
module swg_prescaler
  import swg_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Select
  input  wire logic [2:0] clock_select,
  // Timer tick
  output logic            tick
);

  typedef struct packed {
    logic [9:0] cnt;
    logic       tick;
  } swg_pre_t;

  swg_pre_t r;
  swg_pre_t nxt;

  always_comb begin
    nxt     = r;
    nxt.cnt = r.cnt + 10'h001;
    // Free running divider: all rates share one phase
    unique case (clock_select)
      CS_DIV1:    nxt.tick = 1'b1;               // RL25
      CS_DIV8:    nxt.tick = (r.cnt[2:0] == LAST_8[2:0]);
      CS_DIV64:   nxt.tick = (r.cnt[5:0] == LAST_64[5:0]);
      CS_DIV256:  nxt.tick = (r.cnt[7:0] == LAST_256[7:0]);
      CS_DIV1024: nxt.tick = (r.cnt == LAST_1024);
      default:    nxt.tick = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{cnt: PRE_RST, tick: 1'b0};
    end else begin
      r <= nxt;
    end
  end

  assign tick = r.tick;

endmodule

// file: swg_wave_ch.sv
`timescale 1ns/1ns
module swg_wave_ch
  import swg_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Timing from the counter
  input  wire logic       tick,
  input  wire swg_class_t cls,
  input  wire logic       match,
  input  wire logic       at_bottom,
  input  wire logic       up,
  // Setup
  input  wire logic [1:0] action,
  input  wire logic       toggle_ok,
  // Internal output state
  output logic            oc
);

  typedef struct packed {
    logic oc;
  } swg_ch_t;

  swg_ch_t r;
  swg_ch_t nxt;

  always_comb begin
    nxt = r;
    if (tick && action == ACT_TOGGLE) begin
      if (match && (toggle_ok || cls == CL_NORMAL || cls == CL_CTC)) begin
        nxt.oc = ~r.oc;                          // RL4 RL18
      end
    end else if (tick && action != ACT_OFF) begin
      unique case (cls)
        CL_FAST: begin
          // Bottom wins over a TOP match: compare at TOP gives a flat level
          if (at_bottom) begin
            nxt.oc = ~action[0];                 // RL8 RL9 RL17
          end else if (match) begin
            nxt.oc = action[0];                  // RL8 RL9
          end
        end
        CL_PHASE: begin
          if (match) begin
            nxt.oc = up ? action[0] : ~action[0];  // RL21
          end
        end
        default: begin
          if (match) begin
            nxt.oc = action[0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{oc: 1'b0};
    end else begin
      r <= nxt;
    end
  end

  assign oc = r.oc;

endmodule

// file: swg_wave_gen.sv
`timescale 1ns/1ns
module swg_wave_gen
  import swg_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Setup from the host logic
  input  wire swg_ctrl_t   ctrl,
  // Register writes, one-cycle strobes
  input  wire swg_write_t  wr,
  // Flag clear strobes
  input  wire swg_flags_t  flag_clear,
  // Counter and compare state
  output logic [15:0]      count_value,
  output logic [15:0]      compare_a_value,
  output logic [15:0]      compare_b_value,
  output logic [15:0]      capture_top_register,
  output logic             count_up,
  // Sticky flags
  output swg_flags_t       flags,
  // Waveform pins
  output logic             wave_out_a,
  output logic             wave_oe_a,
  output logic             wave_out_b,
  output logic             wave_oe_b
);

  ////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [15:0] cnt;
    logic        up;
    logic [15:0] cmp_a;
    logic [15:0] cmp_a_buf;
    logic [15:0] cmp_b;
    logic [15:0] cmp_b_buf;
    logic [15:0] capture;
    swg_flags_t  flags;
    logic        pin_a;
    logic        oe_a;
    logic        pin_b;
    logic        oe_b;
  } swg_state_t;

  swg_state_t r;
  swg_state_t nxt;

  logic        tick;
  logic        oc_a;
  logic        oc_b;
  swg_class_t  cls;
  logic [15:0] top;
  logic        at_top;
  logic        match_a;
  logic        match_b;
  logic        top_is_cap;
  logic        top_is_cmp;
  logic        pwm;
  logic        fast_wrap;
  logic        toggle_ok_a;
  logic [15:0] wr_data;
  swg_flags_t  set;

  ////////////////////////////////////////////////////////////////////
  // Timer tick

  swg_prescaler u_pre (
    .sys_clk      (sys_clk),
    .reset_n      (reset_n),
    .clock_select (ctrl.clock_select),
    .tick         (tick)
  );

  ////////////////////////////////////////////////////////////////////
  // Mode decode

  always_comb begin
    cls        = mode_class(ctrl.waveform_mode_select);
    pwm        = (cls == CL_FAST) || (cls == CL_PHASE);
    top_is_cap = (ctrl.waveform_mode_select == MODE_CTC_CAP)
              || (ctrl.waveform_mode_select == MODE_FAST_CAP)
              || (ctrl.waveform_mode_select == MODE_PC_CAP);
    top_is_cmp = (ctrl.waveform_mode_select == MODE_CTC_CMP)
              || (ctrl.waveform_mode_select == MODE_FAST_CMP)
              || (ctrl.waveform_mode_select == MODE_PC_CMP);
    // Capture TOP is read live; compare A TOP is the active copy, loaded from its buffer at TOP in PWM modes
    if (top_is_cap) begin
      top = r.capture;                           // RL14
    end else if (top_is_cmp) begin
      top = r.cmp_a;                             // RL1
    end else begin
      top = fixed_top(ctrl.waveform_mode_select);  // RL10 RL19 RL22 RL23
    end
    at_top      = (r.cnt == top) && (cls != CL_NORMAL);
    match_a     = (r.cnt == r.cmp_a);            // RL26
    match_b     = (r.cnt == r.cmp_b);            // RL26
    fast_wrap   = (cls == CL_FAST) && at_top;
    toggle_ok_a = (ctrl.waveform_mode_select == MODE_FAST_CMP)
               || (ctrl.waveform_mode_select == MODE_PC_CMP);  // RL18
    // Fixed TOP masks the unused high bits of compare writes
    wr_data     = wr.data & fixed_top(ctrl.waveform_mode_select);  // RL13
  end

  ////////////////////////////////////////////////////////////////////
  // Output compare state, one unit per channel

  swg_wave_ch u_ch_a (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .tick      (tick),
    .cls       (cls),
    .match     (match_a),
    .at_bottom (fast_wrap),
    .up        (r.up),
    .action    (ctrl.channel_a_output_action),
    .toggle_ok (toggle_ok_a),
    .oc        (oc_a)
  );

  // Toggle in PWM modes exists only on channel A
  swg_wave_ch u_ch_b (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .tick      (tick),
    .cls       (cls),
    .match     (match_b),
    .at_bottom (fast_wrap),
    .up        (r.up),
    .action    (ctrl.channel_b_output_action),
    .toggle_ok (1'b0),
    .oc        (oc_b)
  );

  ////////////////////////////////////////////////////////////////////
  // Counter, buffers and flags

  always_comb begin
    nxt = r;
    set = '0;

    // Writes: buffer always, active copy at once outside PWM
    if (wr.wr_compare_a) begin
      nxt.cmp_a_buf = wr_data;                   // RL15
      if (!pwm) begin
        nxt.cmp_a = wr_data;                     // RL3
      end
    end
    if (wr.wr_compare_b) begin
      nxt.cmp_b_buf = wr_data;
      if (!pwm) begin
        nxt.cmp_b = wr_data;
      end
    end
    if (wr.wr_capture) begin
      nxt.capture = wr.data;                     // RL14
    end

    if (tick) begin
      set.compare_a_flag = match_a;              // RL12
      set.compare_b_flag = match_b;              // RL12
      unique case (cls)
        CL_CTC: begin
          nxt.up = 1'b1;
          // A TOP of MAX also rolls to zero, so overflow is checked on both paths
          set.overflow_flag = (r.cnt == CNT_MAX);  // RL6
          if (at_top) begin
            nxt.cnt = BOTTOM;                    // RL1
            set.capture_flag = top_is_cap;       // RL2
          end else begin
            // Missed TOP runs on to MAX and wraps
            nxt.cnt = r.cnt + CNT_ONE;           // RL3
          end
        end
        CL_FAST: begin
          nxt.up = 1'b1;                         // RL7
          if (at_top) begin
            nxt.cnt = BOTTOM;                    // RL10
            nxt.cmp_a = r.cmp_a_buf;             // RL15
            nxt.cmp_b = r.cmp_b_buf;
            set.overflow_flag = 1'b1;            // RL11
            set.capture_flag = top_is_cap;       // RL11
          end else begin
            nxt.cnt = r.cnt + CNT_ONE;           // RL14
          end
        end
        CL_PHASE: begin
          if (r.up) begin
            if (at_top) begin
              // TOP shown for exactly one tick, then down
              nxt.up = 1'b0;                     // RL23
              nxt.cnt = r.cnt - CNT_ONE;         // RL20
              nxt.cmp_a = r.cmp_a_buf;
              nxt.cmp_b = r.cmp_b_buf;
              set.capture_flag = top_is_cap;
            end else begin
              nxt.cnt = r.cnt + CNT_ONE;         // RL20
            end
          end else begin
            if (r.cnt == BOTTOM) begin
              nxt.up = 1'b1;                     // RL20
              nxt.cnt = r.cnt + CNT_ONE;
            end else begin
              nxt.cnt = r.cnt - CNT_ONE;
              set.overflow_flag = (r.cnt == CNT_ONE);  // RL24
            end
          end
        end
        default: begin
          nxt.up = 1'b1;
          nxt.cnt = r.cnt + CNT_ONE;
          set.overflow_flag = (r.cnt == CNT_MAX);
        end
      endcase
    end

    // Set beats a clear landing in the same cycle
    nxt.flags = (r.flags & ~flag_clear) | set;

    // Pins show the internal state only when driven as outputs
    nxt.pin_a = oc_a;
    nxt.oe_a  = ctrl.pin_direction_a && (ctrl.channel_a_output_action != ACT_OFF);  // RL5
    nxt.pin_b = oc_b;
    nxt.oe_b  = ctrl.pin_direction_b && (ctrl.channel_b_output_action != ACT_OFF);  // RL5
  end

  ////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{cnt:       BOTTOM,
             up:        1'b1,
             cmp_a:     CMP_RST,
             cmp_a_buf: CMP_RST,
             cmp_b:     CMP_RST,
             cmp_b_buf: CMP_RST,
             capture:   CMP_RST,
             flags:     '0,
             pin_a:     1'b0,
             oe_a:      1'b0,
             pin_b:     1'b0,
             oe_b:      1'b0};
    end else begin
      r <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign count_value          = r.cnt;
  assign compare_a_value      = r.cmp_a;
  assign compare_b_value      = r.cmp_b;
  assign capture_top_register = r.capture;
  assign count_up             = r.up;
  assign flags                = r.flags;
  assign wave_out_a           = r.pin_a;
  assign wave_oe_a            = r.oe_a;
  assign wave_out_b           = r.pin_b;
  assign wave_oe_b            = r.oe_b;

endmodule

// file: swg_wave_gen_properties.sv
`timescale 1ns/1ns
module swg_wave_gen_props
  import swg_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // Watched ports
  input wire swg_ctrl_t   ctrl,
  input wire logic [15:0] count_value,
  input wire logic [15:0] compare_a_value,
  input wire logic        count_up,
  input wire swg_flags_t  flags,
  input wire logic        wave_out_a,
  input wire logic        wave_oe_a
);
  logic [1:0]  age_r;
  logic [15:0] cnt_r;
  logic        rdy;
  logic        adv;
  logic [3:0]  md;
  logic [1:0]  act;
  assign rdy = (age_r == 2'h3);
  assign adv = (count_value != cnt_r);
  assign md  = ctrl.waveform_mode_select;
  assign act = ctrl.channel_a_output_action;
  // Skip the first edges after reset, when past values are stale
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      age_r <= 2'h0;
      cnt_r <= 16'h0000;
    end else begin
      age_r <= rdy ? age_r : age_r + 2'h1;
      cnt_r <= count_value;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  ctc_clear_a: assert property (
    rdy && md == MODE_CTC_CMP && count_value == compare_a_value ##1 adv && $stable(md)
    |-> count_value == BOTTOM && flags.compare_a_flag) else $error("ctc clear wrong");
  match_flag_a: assert property (
    rdy && count_value == compare_a_value ##1 adv |-> flags.compare_a_flag)
    else $error("compare flag missing");
  fast_wrap_a: assert property (
    rdy && md == MODE_FAST8 && count_value == TOP_8 ##1 adv && $stable(md)
    |-> count_value == BOTTOM && flags.overflow_flag) else $error("fast wrap wrong");
  fast_bottom_a: assert property (
    rdy && md == MODE_FAST8 && act[1] && $stable(ctrl) && $past(count_value) == TOP_8
    && count_value == BOTTOM |=> wave_out_a == !$past(act[0], 2))
    else $error("bottom level wrong");
  fast_match_a: assert property (
    rdy && md == MODE_FAST8 && act[1] && count_value == compare_a_value
    && count_value != TOP_8 ##1 adv && $stable(ctrl) |=> wave_out_a == $past(act[0], 2))
    else $error("match level wrong");
  buf_load_a: assert property (
    rdy && md == MODE_FAST8 && $stable(md) && $changed(compare_a_value)
    |-> count_value == BOTTOM && $past(count_value) == TOP_8) else $error("early load");
  pc_top_a: assert property (
    rdy && md == MODE_PC8 && count_value == TOP_8 ##1 adv && $stable(md)
    |-> count_value == 16'h00FE && !count_up) else $error("top turn wrong");
  pc_bottom_a: assert property (
    rdy && md == MODE_PC8 && !count_up && count_value == CNT_ONE ##1 adv && $stable(md)
    |-> count_value == BOTTOM && flags.overflow_flag) else $error("bottom flag missing");
  pin_oe_a: assert property (
    rdy |=> wave_oe_a == $past(ctrl.pin_direction_a && act != ACT_OFF))
    else $error("pin enable wrong");
  stop_hold_a: assert property (
    (rdy && ctrl.clock_select == CS_STOP) [*3] |-> $stable(count_value))
    else $error("count moved while stopped");
endmodule

bind swg_wave_gen swg_wave_gen_props u_props (
  .sys_clk         (sys_clk),
  .reset_n         (reset_n),
  .ctrl            (ctrl),
  .count_value     (count_value),
  .compare_a_value (compare_a_value),
  .count_up        (count_up),
  .flags           (flags),
  .wave_out_a      (wave_out_a),
  .wave_oe_a       (wave_oe_a)
);

// file: swg_wave_gen_tb_top.sv
`timescale 1ns/1ns
module swg_wave_gen_tb_top
  import swg_pkg::*;
;
  logic        sys_clk;
  logic        reset_n;
  swg_ctrl_t   ctrl;
  swg_write_t  wr;
  swg_flags_t  fc;
  swg_flags_t  flags;
  logic [15:0] count_value;
  logic [15:0] compare_a_value;
  logic        count_up;
  logic        wave_out_a;
  logic        wave_oe_a;
  logic [15:0] compare_b_value;
  logic [15:0] capture_top_register;
  logic        wave_out_b;
  logic        wave_oe_b;
  logic [15:0] exp_a;
  logic [15:0] d;
  logic [15:0] c0;
  logic [15:0] tp;
  logic [1:0]  act;
  logic        w0;
  int          n;
  int          bad_count;
  int          cmp_count;

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  swg_wave_gen dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .ctrl(ctrl), .wr(wr), .flag_clear(fc),
    .count_value(count_value), .compare_a_value(compare_a_value),
    .compare_b_value(compare_b_value), .capture_top_register(capture_top_register),
    .count_up(count_up), .flags(flags), .wave_out_a(wave_out_a), .wave_oe_a(wave_oe_a),
    .wave_out_b(wave_out_b), .wave_oe_b(wave_oe_b)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] top_of(input int i);
    return (i == 0) ? 16'h00FF : (i == 1) ? 16'h01FF : 16'h03FF;
  endfunction

  function automatic logic [15:0] div_of(input int i);
    return 16'h0008 << ((i > 0) ? 2 * i + 1 : 0);
  endfunction

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic tk(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wrc(input logic [15:0] v);
    wr.data = v;
    wr.wr_compare_a = 1'b1;
    tk(1);
    wr.wr_compare_a = 1'b0;
  endtask

  task automatic clrf();
    fc = '1;
    tk(1);
    fc = '0;
  endtask

  // Bounded wait for a count, or for the overflow flag when ov is set
  task automatic wt(input logic [15:0] v, input int lim, input bit ov = 1'b0);
    int i;
    for (i = 0; i < lim && (ov ? flags.overflow_flag !== 1'b1 : count_value !== v); i++) begin
      tk(1);
    end
    if (i == lim) begin
      bad_count++;
      $display("[FAIL] t=%0t wait timed out at %h for %h", $time, count_value, v);
      give_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    ctrl = '0;
    ctrl.waveform_mode_select = MODE_CTC_CMP;
    ctrl.clock_select = CS_DIV1;
    ctrl.channel_a_output_action = ACT_TOGGLE;
    ctrl.channel_b_output_action = 2'h3;
    ctrl.pin_direction_a = 1'b1;
    ctrl.pin_direction_b = 1'b1;
    wr = '0;
    fc = '0;
    void'($urandom(80394));
    tk(8);
    chk(count_up, 1'b1);
    reset_n = 1'b1;
    tk(2);
    // Toggle in clear-on-compare, then pin direction off
    d = 16'h0003 + 16'($urandom % 38);
    wrc(d);
    chk(compare_a_value, d);
    wt(d, 100);
    w0 = wave_out_a;
    tk(d + 1);
    chk(count_value, d);
    chk(wave_out_a, !w0);
    chk(flags.compare_a_flag, 1'b1);
    chk(wave_oe_a, 1'b1);
    ctrl.pin_direction_a = 1'b0;
    tk(2);
    chk(wave_oe_a, 1'b0);
    ctrl.pin_direction_a = 1'b1;
    $display("test ctc toggle done");
    // Unbuffered TOP lowered below the count runs through a full wrap
    wrc(16'h0100);
    wt(16'h0080, 300);
    clrf();
    wrc(16'h0010);
    wt(16'h0000, 70000, 1'b1);
    chk(count_value, BOTTOM);
    chk(flags.compare_a_flag, 1'b0);
    $display("test ctc wrap done");
    // Fixed TOP modes with a masked full-scale compare
    for (int i = 0; i < 3; i++) begin
      ctrl.waveform_mode_select = 4'(MODE_FAST8 + i);
      tp = top_of(i);
      act = (i == 1) ? 2'h3 : 2'h2;
      ctrl.channel_a_output_action = act;
      wrc(16'hFFFF);
      wt(tp, 1100);
      tk(1);
      chk(count_value, BOTTOM);
      chk(compare_a_value, tp);
      wt(tp, 1100);
      tk(3);
      chk(wave_out_a, !act[0]);
    end
    $display("test fast fixed top done");
    // Random duty and randomly picked polarity in 8-bit fast mode
    ctrl.waveform_mode_select = MODE_FAST8;
    exp_a = 16'h03FF;
    for (int k = 0; k < 3; k++) begin
      act = 2'h2 + 2'($urandom % 2);
      ctrl.channel_a_output_action = act;
      d = 16'h0002 + 16'($urandom % 252);
      wrc(d);
      chk(compare_a_value, exp_a);
      exp_a = d;
      wt(TOP_8, 300);
      clrf();
      wt(d, 300);
      chk(flags.compare_a_flag, 1'b0);
      chk(wave_out_a, !act[0]);
      wt(d + 16'h0002, 10);
      chk(wave_out_a, act[0]);
      chk(flags.compare_a_flag, 1'b1);
    end
    $display("test fast duty done");
    // Dual slope with a mid-range compare
    ctrl.waveform_mode_select = MODE_PC8;
    ctrl.channel_a_output_action = 2'h2;
    wrc(16'h0040);
    wt(TOP_8, 300);
    tk(1);
    chk(count_value, 16'h00FE);
    chk(count_up, 1'b0);
    chk(compare_a_value, 16'h0040);
    clrf();
    wt(16'h0030, 300);
    chk(wave_out_a, 1'b1);
    wt(BOTTOM, 100);
    chk(flags.overflow_flag, 1'b1);
    wt(16'h0050, 200);
    chk(wave_out_a, 1'b0);
    $display("test phase correct done");
    // Capture register as TOP, unmasked and unbuffered; channel B spike at compare 0
    ctrl.waveform_mode_select = MODE_FAST_CAP;
    ctrl.channel_b_output_action = 2'h2;
    tp = 16'h0080 + 16'($urandom % 64);
    wr.data = tp;
    wr.wr_capture = 1'b1;
    tk(1);
    wr.wr_capture = 1'b0;
    chk(capture_top_register, tp);
    clrf();
    wt(tp, 300);
    tk(1);
    chk(count_value, BOTTOM);
    chk(flags.overflow_flag, 1'b1);
    chk(flags.capture_flag, 1'b1);
    tk(1);
    chk(wave_out_b, 1'b1);
    tk(1);
    chk(wave_out_b, 1'b0);
    chk(wave_oe_b, 1'b1);
    chk(compare_b_value, CMP_RST);
    $display("test capture top done");
    // Prescaler rates; the third interval is free of the switch-over
    ctrl.waveform_mode_select = MODE_NORMAL;
    ctrl.channel_a_output_action = ACT_OFF;
    for (int i = 0; i < 4; i++) begin
      ctrl.clock_select = 3'(CS_DIV8 + i);
      for (int j = 0; j < 3; j++) begin
        c0 = count_value;
        for (n = 0; n < 2100 && count_value === c0; n++) begin
          tk(1);
        end
      end
      chk(16'(n), div_of(i));
    end
    ctrl.clock_select = CS_STOP;
    tk(3);
    c0 = count_value;
    tk(20);
    chk(count_value, c0);
    $display("test prescaler done");
    give_verdict();
  end
endmodule
